// ==== common/imr_pkg.sv ====
// Shared constants and types of the I2C master byte engine.
// Assumes a single system clock; the pads are open drain, driven low only.

package imr_pkg;

  // ----------------------------------------------------------------
  // Widths and bit counts
  // ----------------------------------------------------------------
  localparam int unsigned IMR_BYTE_W = 8;
  localparam int unsigned IMR_CNT_W = 4;
  localparam logic [3:0] IMR_BIT_EIGHTH = 4'h7;  // Index of eighth clock
  localparam logic [3:0] IMR_BIT_NINTH = 4'h8;   // Index of acknowledge clock
  localparam logic [3:0] IMR_BIT_FIRST = 4'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IMR_BYTE_RST = 8'h00;
  localparam logic [7:0] IMR_BRG_RST = 8'h00;
  localparam logic IMR_LINE_IDLE = 1'b1;         // Released bus reads high
  localparam logic IMR_FLAG_RST = 1'b0;

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RS_HOLD,
    ST_RS_SDA_HI,
    ST_RS_SCL_REL,
    ST_RS_HIGH,
    ST_RS_SDA_LOW,
    ST_TX_LOW,
    ST_TX_REL,
    ST_TX_HIGH,
    ST_RX_LOW,
    ST_RX_REL,
    ST_RX_HIGH
  } imr_state_t;

endpackage

// ==== logic/imr_sync2.sv ====
// Two-flop synchroniser for the SCL and SDA pad inputs.
// Assumes inputs are asynchronous to CLK_SYS; idle level is high.

`timescale 1ns/1ps
`default_nettype none

module imr_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pad levels in, synchronised levels out
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);

  logic [1:0] stage1;

  // ----------------------------------------------------------------
  // One synchroniser per line
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_line
      // First flop feeds only the second flop
      always_ff @(posedge clk) begin
        if (rst) begin
          stage1[g] <= imr_pkg::IMR_LINE_IDLE;
          sync_out[g] <= imr_pkg::IMR_LINE_IDLE;
        end else begin
          stage1[g] <= async_in[g];
          sync_out[g] <= stage1[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ==== logic/imr_baud_gen.sv ====
// Baud rate generator: a down counter that marks one bit phase, low or high.
// Assumes the engine loads it at every phase and gates its counting.

`timescale 1ns/1ps
`default_nettype none

module imr_baud_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control from the engine
  input wire logic load,
  input wire logic run,
  input wire logic [7:0] reload,
  // Status
  output logic timeout,
  output logic [7:0] count
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Load wins so every phase starts from a fresh reload value
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= imr_pkg::IMR_BRG_RST;
    end else if (load) begin
      count <= reload;
    end else if (run && count != 8'h00) begin
      count <= count - 8'h01;
    end
  end

  // Rollover seen only while counting is allowed
  assign timeout = run && (count == 8'h00);

endmodule

`default_nettype wire

// ==== logic/imr_master.sv ====
// I2C master byte engine: repeated start, byte transmit, byte receive.
// Assumes software strobes are one-cycle pulses on CLK_SYS and the
// SCL/SDA pads are open drain with external pull-ups.
//
// Behaviour
// - Restart from idle pulls SCL low, then releases SDA for one period.
// - At timeout SCL is released only with SDA high; high phase one period.
// - SDA low one period, SCL low, restart bit clears, SDA stays low.
// - Start seen on pins sets status; interrupt waits for generator timeout.
// - Restart request outside idle is ignored.
// - Restart collision: SDA low at SCL rise, or SCL falls early.
// - Buffer write sets buffer full and starts the transmission.
// - Bit placed after SCL falls; low one period, high one period.
// - Eighth falling edge clears buffer full and releases SDA.
// - Ninth bit response stored: zero acknowledge, one no acknowledge.
// - After ninth clock set interrupt, stop generator, hold SCL low.
// - Buffer write while busy sets write collision, buffer unchanged.
// - Receive request outside idle is ignored.
// - Receive toggles SCL on each rollover and shifts SDA in.
// - After eighth receive fall, copy byte, set flags, back to idle.
// - Reading the buffer in receive clears buffer full.
// - Completed byte with buffer still full sets receive overflow.
// - Interrupt raised once the restart condition has finished.
// - Address byte shifts seven bits then direction, then releases SDA.
// - Every generator reload uses the eight-bit reload value.
// - Generator holds while SCL is released but not yet seen high.

`timescale 1ns/1ps
`default_nettype none

module imr_master (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // I2C pads, open drain
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // Software control strobes
  input wire logic RESTART_SET,
  input wire logic RECEIVE_SET,
  input wire logic BUF_WR,
  input wire logic [7:0] BUF_WDATA,
  input wire logic BUF_RD,
  input wire logic IRQ_CLR,
  input wire logic WRITE_COLLISION_FLAG_CLR,
  input wire logic OVF_CLR,
  input wire logic START_CLR,
  input wire logic BCOL_CLR,
  // Configuration
  input wire logic [7:0] RELOAD_VALUE,
  // Status and data
  output logic [7:0] BUF_RDATA,
  output logic RESTART_REQUEST,
  output logic RECEIVE_REQUEST,
  output logic BUFFER_FULL,
  output logic WRITE_COLLISION,
  output logic RECEIVE_OVERFLOW,
  output logic ACK_RESULT,
  output logic IRQ_FLAG,
  output logic START_SEEN,
  output logic BUS_COLLISION,
  output logic BUSY
);

  imr_pkg::imr_state_t state, next_state;
  logic scl_drive, next_scl;
  logic sda_drive, next_sda;
  logic [1:0] pins_s;
  logic scl_s, sda_s, scl_prev, sda_prev;
  logic brg_load, brg_run, brg_timeout;
  logic [7:0] brg_count;
  logic [3:0] bit_cnt;
  logic [7:0] shift_register;
  logic [7:0] xfer_buffer;
  logic restart_request, receive_request;
  logic buffer_full, write_collision, receive_overflow;
  logic ack_result_flag, serial_port_irq_flag, start_seen, bus_collision;
  logic idle, restart_go, tx_go, rx_go;
  logic rs_done, rs_coll, tx_done, rx_done, tx_eighth;
  logic tx_shift, rx_sample, ack_cap, bit_inc;

  // ----------------------------------------------------------------
  // Pad synchronisers and baud generator
  // ----------------------------------------------------------------
  imr_sync2 u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .async_in({SCL_I, SDA_I}),
    .sync_out(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  imr_baud_gen u_brg (
    .clk(CLK_SYS),
    .rst(RST),
    .load(brg_load),
    .run(brg_run),
    .reload(RELOAD_VALUE),
    .timeout(brg_timeout),
    .count(brg_count)
  );

  // ----------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------
  // Only one command per idle cycle; restart beats write beats receive
  assign idle = (state == imr_pkg::ST_IDLE);
  assign restart_go = RESTART_SET && idle;
  assign tx_go = BUF_WR && idle && !RESTART_SET && !write_collision;
  assign rx_go = RECEIVE_SET && idle && !RESTART_SET && !BUF_WR;

  // ----------------------------------------------------------------
  // Engine next state and line drive
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_scl = scl_drive;
    next_sda = sda_drive;
    brg_load = 1'b0;
    brg_run = 1'b0;
    rs_done = 1'b0;
    rs_coll = 1'b0;
    tx_done = 1'b0;
    rx_done = 1'b0;
    tx_eighth = 1'b0;
    tx_shift = 1'b0;
    rx_sample = 1'b0;
    ack_cap = 1'b0;
    bit_inc = 1'b0;
    case (state)
      imr_pkg::ST_IDLE: begin
        if (restart_go) begin
          next_scl = 1'b1;
          next_state = imr_pkg::ST_RS_HOLD;
        end else if (tx_go) begin
          next_scl = 1'b1;
          next_sda = ~BUF_WDATA[7];
          brg_load = 1'b1;
          next_state = imr_pkg::ST_TX_LOW;
        end else if (rx_go) begin
          next_scl = 1'b1;
          next_sda = 1'b0;
          brg_load = 1'b1;
          next_state = imr_pkg::ST_RX_LOW;
        end
      end
      imr_pkg::ST_RS_HOLD: begin
        // Wait until SCL really reads low before timing the release
        if (!scl_s) begin
          brg_load = 1'b1;
          next_sda = 1'b0;
          next_state = imr_pkg::ST_RS_SDA_HI;
        end
      end
      imr_pkg::ST_RS_SDA_HI: begin
        brg_run = 1'b1;
        if (brg_timeout) begin
          if (sda_s) begin
            next_scl = 1'b0;
            next_state = imr_pkg::ST_RS_SCL_REL;
          end else begin
            brg_load = 1'b1; // SDA held by someone: try again next period
          end
        end
      end
      imr_pkg::ST_RS_SCL_REL: begin
        if (scl_s) begin
          if (!sda_s) begin
            rs_coll = 1'b1;
          end else begin
            brg_load = 1'b1;
            next_state = imr_pkg::ST_RS_HIGH;
          end
        end
      end
      imr_pkg::ST_RS_HIGH: begin
        brg_run = 1'b1;
        if (!scl_s) begin
          rs_coll = 1'b1;
        end else if (brg_timeout) begin
          next_sda = 1'b1;
          brg_load = 1'b1;
          next_state = imr_pkg::ST_RS_SDA_LOW;
        end
      end
      imr_pkg::ST_RS_SDA_LOW: begin
        brg_run = 1'b1;
        if (brg_timeout) begin
          next_scl = 1'b1;
          rs_done = 1'b1;
          next_state = imr_pkg::ST_IDLE;
        end
      end
      imr_pkg::ST_TX_LOW: begin
        brg_run = 1'b1;
        if (brg_timeout) begin
          next_scl = 1'b0;
          next_state = imr_pkg::ST_TX_REL;
        end
      end
      imr_pkg::ST_TX_REL: begin
        if (scl_s) begin
          brg_load = 1'b1;
          ack_cap = (bit_cnt == imr_pkg::IMR_BIT_NINTH);
          next_state = imr_pkg::ST_TX_HIGH;
        end
      end
      imr_pkg::ST_TX_HIGH: begin
        brg_run = 1'b1;
        if (brg_timeout) begin
          next_scl = 1'b1;
          if (bit_cnt == imr_pkg::IMR_BIT_NINTH) begin
            tx_done = 1'b1;
            next_sda = 1'b0;
            next_state = imr_pkg::ST_IDLE;
          end else begin
            bit_inc = 1'b1;
            tx_shift = 1'b1;
            brg_load = 1'b1;
            next_state = imr_pkg::ST_TX_LOW;
            if (bit_cnt == imr_pkg::IMR_BIT_EIGHTH) begin
              tx_eighth = 1'b1;
              next_sda = 1'b0;
            end else begin
              next_sda = ~shift_register[6];
            end
          end
        end
      end
      imr_pkg::ST_RX_LOW: begin
        brg_run = 1'b1;
        if (brg_timeout) begin
          next_scl = 1'b0;
          next_state = imr_pkg::ST_RX_REL;
        end
      end
      imr_pkg::ST_RX_REL: begin
        if (scl_s) begin
          brg_load = 1'b1;
          rx_sample = 1'b1;
          next_state = imr_pkg::ST_RX_HIGH;
        end
      end
      imr_pkg::ST_RX_HIGH: begin
        brg_run = 1'b1;
        if (brg_timeout) begin
          next_scl = 1'b1;
          if (bit_cnt == imr_pkg::IMR_BIT_EIGHTH) begin
            rx_done = 1'b1;
            next_state = imr_pkg::ST_IDLE;
          end else begin
            bit_inc = 1'b1;
            brg_load = 1'b1;
            next_state = imr_pkg::ST_RX_LOW;
          end
        end
      end
      default: begin
        next_state = imr_pkg::ST_IDLE;
      end
    endcase
    // Collision gives the bus back at once
    if (rs_coll) begin
      next_scl = 1'b0;
      next_sda = 1'b0;
      next_state = imr_pkg::ST_IDLE;
    end
  end

  // State and line drive registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= imr_pkg::ST_IDLE;
      scl_drive <= 1'b0;
      sda_drive <= 1'b0;
    end else begin
      state <= next_state;
      scl_drive <= next_scl;
      sda_drive <= next_sda;
    end
  end

  // ----------------------------------------------------------------
  // Bit counter and shifter
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      bit_cnt <= imr_pkg::IMR_BIT_FIRST;
    end else if (tx_go || rx_go) begin
      bit_cnt <= imr_pkg::IMR_BIT_FIRST;
    end else if (bit_inc) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Transmit shifts MSB first; receive shifts sampled SDA in at the bottom
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      shift_register <= imr_pkg::IMR_BYTE_RST;
    end else if (tx_go) begin
      shift_register <= BUF_WDATA;
    end else if (tx_shift) begin
      shift_register <= {shift_register[6:0], 1'b0};
    end else if (rx_sample) begin
      shift_register <= {shift_register[6:0], sda_s};
    end
  end

  // Buffer keeps its contents on a refused write
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      xfer_buffer <= imr_pkg::IMR_BYTE_RST;
    end else if (tx_go) begin
      xfer_buffer <= BUF_WDATA;
    end else if (rx_done) begin
      xfer_buffer <= shift_register;
    end
  end

  // ----------------------------------------------------------------
  // Request bits, cleared by hardware on completion
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      restart_request <= imr_pkg::IMR_FLAG_RST;
      receive_request <= imr_pkg::IMR_FLAG_RST;
    end else begin
      if (restart_go) begin
        restart_request <= 1'b1;
      end else if (rs_done || rs_coll) begin
        restart_request <= 1'b0;
      end
      if (rx_go) begin
        receive_request <= 1'b1;
      end else if (rx_done) begin
        receive_request <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags; every hardware set wins over a same-cycle clear
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      buffer_full <= imr_pkg::IMR_FLAG_RST;
    end else if (tx_go || rx_done) begin
      buffer_full <= 1'b1;
    end else if (tx_eighth) begin
      buffer_full <= 1'b0;
    end else if (BUF_RD && state != imr_pkg::ST_TX_LOW && state != imr_pkg::ST_TX_REL
                 && state != imr_pkg::ST_TX_HIGH) begin
      buffer_full <= 1'b0;
    end
  end

  // Refused writes stay flagged until software acknowledges them
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      write_collision <= imr_pkg::IMR_FLAG_RST;
    end else if (BUF_WR && !tx_go) begin
      write_collision <= 1'b1;
    end else if (WRITE_COLLISION_FLAG_CLR) begin
      write_collision <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      receive_overflow <= imr_pkg::IMR_FLAG_RST;
    end else if (rx_done && buffer_full) begin
      receive_overflow <= 1'b1;
    end else if (OVF_CLR) begin
      receive_overflow <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ack_result_flag <= imr_pkg::IMR_FLAG_RST;
    end else if (ack_cap) begin
      ack_result_flag <= sda_s;
    end
  end

  // Only software clears the interrupt flag
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      serial_port_irq_flag <= imr_pkg::IMR_FLAG_RST;
    end else if (rs_done || tx_done || rx_done) begin
      serial_port_irq_flag <= 1'b1;
    end else if (IRQ_CLR) begin
      serial_port_irq_flag <= 1'b0;
    end
  end

  // Start pattern watched on synchronised levels, independent of the engine
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      scl_prev <= imr_pkg::IMR_LINE_IDLE;
      sda_prev <= imr_pkg::IMR_LINE_IDLE;
      start_seen <= imr_pkg::IMR_FLAG_RST;
      bus_collision <= imr_pkg::IMR_FLAG_RST;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
      if (sda_prev && !sda_s && scl_prev && scl_s) begin
        start_seen <= 1'b1;
      end else if (START_CLR) begin
        start_seen <= 1'b0;
      end
      if (rs_coll) begin
        bus_collision <= 1'b1;
      end else if (BCOL_CLR) begin
        bus_collision <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE = scl_drive;
  assign SDA_OE = sda_drive;
  assign BUF_RDATA = xfer_buffer;
  assign RESTART_REQUEST = restart_request;
  assign RECEIVE_REQUEST = receive_request;
  assign BUFFER_FULL = buffer_full;
  assign WRITE_COLLISION = write_collision;
  assign RECEIVE_OVERFLOW = receive_overflow;
  assign ACK_RESULT = ack_result_flag;
  assign IRQ_FLAG = serial_port_irq_flag;
  assign START_SEEN = start_seen;
  assign BUS_COLLISION = bus_collision;
  assign BUSY = !idle; // Engine active

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  chk_restart_ignored: assert property (
    RESTART_SET && !idle && !restart_request |=> !restart_request)
    else $error("restart accepted while busy");
  chk_receive_ignored: assert property (
    RECEIVE_SET && !idle && !receive_request |=> !receive_request)
    else $error("receive accepted while busy");
  chk_write_collision_flag_buffer: assert property (
    BUF_WR && !idle && !rx_done |=> write_collision && $stable(xfer_buffer))
    else $error("busy write not refused");
  chk_write_starts: assert property (
    tx_go |=> buffer_full && state == imr_pkg::ST_TX_LOW && scl_drive)
    else $error("write did not start transmit");
  chk_ack_release: assert property (
    tx_eighth |=> !buffer_full && !sda_drive)
    else $error("eighth fall did not release SDA");
  chk_stretch_hold: assert property (
    (state == imr_pkg::ST_TX_REL || state == imr_pkg::ST_RX_REL
     || state == imr_pkg::ST_RS_SCL_REL) && !scl_s |=> $stable(brg_count))
    else $error("generator ran during stretch");
  chk_rx_complete: assert property (
    $fell(receive_request) |-> buffer_full && serial_port_irq_flag && scl_drive && idle)
    else $error("receive completion incomplete");
  chk_overflow_set: assert property (
    rx_done && buffer_full |=> receive_overflow)
    else $error("overflow missed");
  chk_irq_sticky: assert property (
    serial_port_irq_flag && !IRQ_CLR |=> serial_port_irq_flag)
    else $error("interrupt flag dropped by hardware");
  chk_restart_end: assert property (
    rs_done |=> scl_drive && sda_drive && !restart_request && serial_port_irq_flag)
    else $error("restart did not end with lines low");

  cov_restart_done: cover property (rs_done);
  cov_tx_byte: cover property (tx_done);
  cov_rx_overflow: cover property (rx_done && buffer_full);

endmodule

`default_nettype wire

// ==== verif/imr_slave_model.sv ====
// Behavioural I2C slave: acknowledges, returns read data, may stretch SCL.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module imr_slave_model (
  // Bench control
  input wire logic rst,
  input wire logic nack,
  input wire logic rd_mode,
  input wire logic stretch,
  input wire logic [7:0] rd_byte,
  // Bus levels and pull-downs
  input wire logic scl,
  output logic scl_oe,
  output logic sda_oe
);
  logic [3:0] bitn;
  // Slot counter on SCL falls, nine slots per written byte
  always @(negedge scl or posedge rst) begin
    if (rst) begin
      bitn <= 4'h0;
    end else begin
      bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
    end
  end
  // Data changes only while SCL is low, so it never looks like a start
  assign sda_oe = rd_mode ? (bitn < 4'h8 && !rd_byte[3'h7 - bitn[2:0]])
                          : (bitn == 4'h8 && !nack);
  // Stretch outlasts the master's low phase to test clock holding
  initial scl_oe = 1'b0;
  always @(negedge scl) begin
    if (stretch) begin
      scl_oe = 1'b1;
      #400 scl_oe = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/i2c_master_restart_tx_rx_bench.sv ====
// Self-checking bench of the I2C master byte engine against a slave model.
// Assumes open-drain pads with pull-ups, resolved here from all enables.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module i2c_master_restart_tx_rx_bench;
  logic CLK_SYS, RST, prst, nack, rd_mode, stretch, seen;
  logic [8:0] stb, cap;
  logic [7:0] wdata, reload, rd_byte, b, rdata;
  logic scl_oe, sda_oe, s_scl_oe, s_sda_oe, scl, sda, scl_o, sda_o, busy;
  logic rs_req, rx_req, full, write_collision_flag, ovf, ack, irq, st_seen, bcol;
  int seed, fail_count, n_checks, cyc, i;
  // Wired-AND bus with pull-ups
  assign scl = (scl_oe ? scl_o : 1'b1) && !s_scl_oe;
  assign sda = (sda_oe ? sda_o : 1'b1) && !s_sda_oe;
  imr_master dut (.CLK_SYS(CLK_SYS), .RST(RST), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .RESTART_SET(stb[0]), .RECEIVE_SET(stb[1]),
    .BUF_WR(stb[2]), .BUF_WDATA(wdata), .BUF_RD(stb[3]), .IRQ_CLR(stb[4]),
    .WRITE_COLLISION_FLAG_CLR(stb[5]), .OVF_CLR(stb[6]), .START_CLR(stb[7]), .BCOL_CLR(stb[8]),
    .RELOAD_VALUE(reload), .BUF_RDATA(rdata), .RESTART_REQUEST(rs_req),
    .RECEIVE_REQUEST(rx_req), .BUFFER_FULL(full), .WRITE_COLLISION(write_collision_flag),
    .RECEIVE_OVERFLOW(ovf), .ACK_RESULT(ack), .IRQ_FLAG(irq), .START_SEEN(st_seen),
    .BUS_COLLISION(bcol), .BUSY(busy));
  imr_slave_model slave (.rst(prst), .nack(nack), .rd_mode(rd_mode), .stretch(stretch),
    .rd_byte(rd_byte), .scl(scl), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe));
  // Clock
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  // Bits seen at SCL rise, start patterns on the wires
  always @(posedge scl) cap <= {cap[7:0], sda};
  always @(negedge sda) if (scl) seen <= 1'b1;
  // Hang guard, far above the thousand or so cycles needed
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One-cycle strobe; the edge after it has landed when this returns
  task automatic pulse(input int k, input logic [7:0] d);
    @(posedge CLK_SYS);
    wdata <= d;
    stb[k] <= 1'b1;
    @(posedge CLK_SYS);
    stb[k] <= 1'b0;
    #1;
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge CLK_SYS);
      n++;
    end
    #1;
    `CHK("irq", 1'b1, irq)
  endtask
  // Slave counter restart before each operation
  task automatic arm(input logic m, input logic [7:0] v);
    rd_mode = m;
    rd_byte = v;
    cap = 9'h000;
    prst = 1'b1;
    #1 prst = 1'b0;
  endtask
  task automatic rs();
    arm(1'b0, 8'h00);
    seen = 1'b0;
    pulse(0, 8'h00);
    `CHK("rs_req", 1'b1, rs_req)
    wait_irq();
    `CHK("rs_clr", 1'b0, rs_req)
    `CHK("rs_sda", 1'b0, sda)
    `CHK("rs_scl", 1'b0, scl)
    `CHK("start", 1'b1, st_seen)
    `CHK("wire_start", 1'b1, seen)
    `CHK("bcol", 1'b0, bcol)
    pulse(4, 8'h00);
    pulse(7, 8'h00);
    $display("test restart done");
  endtask
  task automatic tx(input logic [7:0] v, input logic col);
    arm(1'b0, 8'h00);
    pulse(2, v);
    `CHK("full", 1'b1, full)
    `CHK("busy", 1'b1, busy)
    if (col) begin
      pulse(2, ~v);
      pulse(0, v);
      pulse(1, v);
      `CHK("write_collision_flag", 1'b1, write_collision_flag)
      `CHK("buf", v, rdata)
      `CHK("rs_busy", 1'b0, rs_req)
      `CHK("rx_busy", 1'b0, rx_req)
      pulse(5, v);
      `CHK("write_collision_flag_clr", 1'b0, write_collision_flag)
    end
    wait_irq();
    `CHK("byte", v, cap[8:1])
    `CHK("busy_end", 1'b0, busy)
    `CHK("ack", nack, ack)
    `CHK("full_end", 1'b0, full)
    `CHK("scl_low", 1'b0, scl)
    `CHK("sda_rel", 1'b1, sda)
    repeat (10) @(posedge CLK_SYS);
    `CHK("irq_hold", 1'b1, irq)
    pulse(4, v);
    $display("test tx %h done", v);
  endtask
  // An early read while shifting in frees the buffer before the byte lands
  task automatic rx(input logic [7:0] v, input logic ovf_exp, input logic rd,
      input logic early);
    arm(1'b1, v);
    pulse(1, v);
    `CHK("rx_req", 1'b1, rx_req)
    if (early) pulse(3, v);
    wait_irq();
    `CHK("rx_byte", v, rdata)
    `CHK("rx_full", 1'b1, full)
    `CHK("rx_done", 1'b0, rx_req)
    `CHK("rx_scl", 1'b0, scl)
    `CHK("ovf", ovf_exp, ovf)
    pulse(4, v);
    if (rd) begin
      pulse(3, v);
      `CHK("rd_clr", 1'b0, full)
    end
    $display("test rx %h done", v);
  endtask
  // Main sequence: restart, address then data bytes, restart, three reads
  initial begin
    seed = 13498;
    {fail_count, n_checks, cyc} = '0;
    {RST, prst, nack, rd_mode, stretch, seen} = 6'h20;
    {stb, cap, wdata, rd_byte} = '0;
    reload = 8'h03;
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    rs();
    for (i = 0; i < 5; i++) begin
      b = 8'($random(seed));
      nack = b[7];
      stretch = (i == 2);
      @(posedge CLK_SYS);
      reload <= 8'h01 + (b & 8'h03);
      b = 8'($random(seed));
      if (i == 0) b[0] = 1'b1;
      tx(b, i == 1);
    end
    stretch = 1'b0;
    rs();
    b = 8'($random(seed));
    rx(b, 1'b0, 1'b0, 1'b0);
    rx(~b, 1'b0, 1'b0, 1'b1);
    rx(b, 1'b1, 1'b1, 1'b0);
    pulse(6, b);
    `CHK("ovf_clr", 1'b0, ovf)
    stop_test();
  end
endmodule
`default_nettype wire
